/* File: nv_access_pkg.sv */
// constants, field positions and state type of the data nonvolatile access block
// assumes a 32-bit apb master and a 25 mhz system clock
package nv_access_pkg;

    // apb byte offsets
    localparam logic [7:0] OFF_ADDR_LO = 8'h00;
    localparam logic [7:0] OFF_ADDR_HI = 8'h04;
    localparam logic [7:0] OFF_VALUE = 8'h08;
    localparam logic [7:0] OFF_CTRL = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STS = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFF_GIE = 8'h18;

    // nv_access_control field positions
    localparam int BIT_READ_GO = 0;
    localparam int BIT_PROGRAM_GO = 1;
    localparam int BIT_PROGRAM_ARM = 2;
    localparam int BIT_READY_IRQ_ENABLE = 3;
    localparam int BIT_PROG_MODE_LO = 4;
    localparam int BIT_PROG_MODE_HI = 5;

    // interrupt status / mask positions
    localparam int BIT_STS_PROG_DONE = 0;
    localparam int BIT_STS_READ_DONE = 1;

    // prog_mode_field encodings
    localparam logic [1:0] MODE_ATOMIC = 2'h0;
    localparam logic [1:0] MODE_ERASE = 2'h1;
    localparam logic [1:0] MODE_WRITE = 2'h2;
    localparam logic [1:0] MODE_RESERVED = 2'h3;

    // reset values and the erased cell value
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // cpu clock rate in khz, and cpu clock timing in cycles
    localparam int CLK_SYS_KHZ = 25000;
    localparam logic [2:0] ARM_WINDOW_CYCLES = 3'h4;
    localparam logic [2:0] READ_STALL_CYCLES = 3'h4;
    localparam logic [2:0] PROG_STALL_CYCLES = 3'h2;

    // programming times in microseconds, counted in oscillator ticks
    localparam int PROG_ATOMIC_US = 3400;
    localparam int PROG_SPLIT_US = 1800;
    localparam int OSC_TICK_KHZ = 1000;
    localparam logic [11:0] PROG_ATOMIC_TICKS =
        12'(PROG_ATOMIC_US * OSC_TICK_KHZ / 1000);
    localparam logic [11:0] PROG_SPLIT_TICKS =
        12'(PROG_SPLIT_US * OSC_TICK_KHZ / 1000);

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] value;
        logic [1:0] mode;
        logic arm;
        logic [2:0] arm_cnt;
        logic busy;
        logic [1:0] op;
        logic [11:0] prog_cnt;
        logic rie;
        logic gie;
        logic [1:0] sts;
        logic [1:0] mask;
        logic [2:0] stall_cnt;
        logic stall;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic osc_s1;
        logic osc_s2;
        logic osc_s3;
    } state_t;

endpackage : nv_access_pkg

/* File: nv_cell_array.sv */
// byte array that stands in for the nonvolatile cells
// assumes one erase and/or write strobe per completed programming operation
`timescale 1ns/100ps
`default_nettype none
module nv_cell_array
    import nv_access_pkg::*;
(
    input wire logic clk_i,
    input wire logic erase_i,
    input wire logic write_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);

    logic [7:0] cells [256];

    // write without erase can only clear bits, as a real cell would
    always_ff @(posedge clk_i) begin
        if (erase_i && write_i) begin
            cells[addr_i] <= wdata_i;
        end else if (erase_i) begin
            cells[addr_i] <= ERASED_BYTE;
        end else if (write_i) begin
            cells[addr_i] <= cells[addr_i] & wdata_i;
        end
    end

    assign rdata_o = cells[addr_i];

endmodule : nv_cell_array
`default_nettype wire

/* File: nv_access_ctrl.sv */
// apb register front end and programming sequencer for a 256-byte data store
// assumes apb on CLK_SYS_I and a free-running toggle from the calibrated
// oscillator on OSC_TOGGLE_I, one toggle per programming tick
//
// How it works
// RULE1 - 256 linear bytes, each read or written alone
// RULE2 - address, data, control registers on the bus
// RULE3 - read start stalls cpu four cycles
// RULE4 - program start stalls cpu two cycles
// RULE5 - software loads address and value first
// RULE6 - mode 00 armed go does erase plus write
// RULE7 - program_go reads one until operation ends
// RULE8 - no other operation while programming
// RULE9 - mode 01 armed go erases only
// RULE10 - mode 10 armed go writes only
// RULE11 - software erases before a write-only operation
// RULE12 - programming timed by oscillator ticks
// RULE13 - read_go loads addressed byte into value
// RULE14 - 3.4 ms atomic, 1.8 ms split, 11 reserved
// RULE15 - arm clears after four cycles, gates go
// RULE16 - mode writes ignored while busy, reset 00
// RULE17 - ready interrupt level while idle and enabled
// RULE18 - requests while busy ignored, registers unchanged; here rie, arm, mask and gie writes still land while busy
`timescale 1ns/100ps
`default_nettype none
module nv_access_ctrl
    import nv_access_pkg::*;
#(
    parameter logic [11:0] ATOMIC_TICKS = PROG_ATOMIC_TICKS,
    parameter logic [11:0] SPLIT_TICKS = PROG_SPLIT_TICKS
)
(
    input wire logic CLK_SYS_I,
    input wire logic ARST_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic OSC_TOGGLE_I,
    output logic CPU_STALL_O,
    output logic IRQ_O
);

    state_t st_r;
    state_t st_nxt;
    logic [7:0] mem_rdata;
    logic mem_erase;
    logic mem_write;
    logic osc_edge;
    logic access;
    logic commit;
    logic rd_start;
    logic pg_start;
    logic arm_wr;

    function automatic logic reg_hit(input logic [7:0] a,
                                     input logic [7:0] off);
        return a == off;
    endfunction : reg_hit

    function automatic logic mapped(input logic [7:0] a);
        return reg_hit(a, OFF_ADDR_LO) || reg_hit(a, OFF_ADDR_HI) ||
               reg_hit(a, OFF_VALUE) || reg_hit(a, OFF_CTRL) ||
               reg_hit(a, OFF_IRQ_STS) || reg_hit(a, OFF_IRQ_MASK) ||
               reg_hit(a, OFF_GIE);
    endfunction : mapped

    nv_cell_array u_cells (
        .clk_i(CLK_SYS_I),
        .erase_i(mem_erase),
        .write_i(mem_write),
        .addr_i(st_r.addr),
        .wdata_i(st_r.value),
        .rdata_o(mem_rdata)
    ); // RULE1

    always_comb begin
        st_nxt = st_r;
        mem_erase = 1'b0;
        mem_write = 1'b0;
        rd_start = 1'b0;
        pg_start = 1'b0;

        // oscillator toggle synchroniser, edge taken after the second stage
        st_nxt.osc_s1 = OSC_TOGGLE_I;
        st_nxt.osc_s2 = st_r.osc_s1;
        st_nxt.osc_s3 = st_r.osc_s2;
        osc_edge = st_r.osc_s2 ^ st_r.osc_s3;

        access = PSEL_I & PENABLE_I;
        commit = access & st_r.pready;

        // the bus waits out any cpu stall before answering
        st_nxt.pready = access & ~st_r.pready & (st_r.stall_cnt == 3'h0); // RULE3 RULE4
        st_nxt.pslverr = st_nxt.pready & ~mapped(PADDR_I);
        if (st_nxt.pready) begin
            st_nxt.prdata = 32'h0;
            unique case (1'b1)
                reg_hit(PADDR_I, OFF_ADDR_LO): st_nxt.prdata[7:0] = st_r.addr;
                reg_hit(PADDR_I, OFF_VALUE): st_nxt.prdata[7:0] = st_r.value;
                reg_hit(PADDR_I, OFF_CTRL): begin
                    st_nxt.prdata[BIT_PROGRAM_GO] = st_r.busy; // RULE7
                    st_nxt.prdata[BIT_PROGRAM_ARM] = st_r.arm;
                    st_nxt.prdata[BIT_READY_IRQ_ENABLE] = st_r.rie;
                    st_nxt.prdata[BIT_PROG_MODE_HI:BIT_PROG_MODE_LO] =
                        st_r.mode;
                end
                reg_hit(PADDR_I, OFF_IRQ_STS): st_nxt.prdata[1:0] = st_r.sts;
                reg_hit(PADDR_I, OFF_IRQ_MASK): st_nxt.prdata[1:0] = st_r.mask;
                reg_hit(PADDR_I, OFF_GIE): st_nxt.prdata[0] = st_r.gie;
                default: st_nxt.prdata = 32'h0;
            endcase
        end

        // arm window counts down on the cpu clock
        if (st_r.arm_cnt != 3'h0) begin
            st_nxt.arm_cnt = st_r.arm_cnt - 3'h1;
            if (st_r.arm_cnt == 3'h1) begin
                st_nxt.arm = 1'b0; // RULE15
            end
        end

        if (st_r.stall_cnt != 3'h0) begin
            st_nxt.stall_cnt = st_r.stall_cnt - 3'h1;
        end

        // status read clears first so that a same-cycle event still lands
        if (commit && !PWRITE_I && reg_hit(PADDR_I, OFF_IRQ_STS)) begin
            st_nxt.sts = 2'h0;
        end

        if (commit && PWRITE_I) begin // RULE2
            if (reg_hit(PADDR_I, OFF_ADDR_LO) && !st_r.busy) begin
                st_nxt.addr = PWDATA_I[7:0]; // RULE8
            end
            if (reg_hit(PADDR_I, OFF_VALUE) && !st_r.busy) begin
                st_nxt.value = PWDATA_I[7:0]; // RULE8
            end
            if (reg_hit(PADDR_I, OFF_IRQ_MASK)) begin
                st_nxt.mask = PWDATA_I[1:0];
            end
            if (reg_hit(PADDR_I, OFF_GIE)) begin
                st_nxt.gie = PWDATA_I[0];
            end
            if (reg_hit(PADDR_I, OFF_CTRL)) begin
                st_nxt.rie = PWDATA_I[BIT_READY_IRQ_ENABLE];
                if (!st_r.busy) begin
                    st_nxt.mode =
                        PWDATA_I[BIT_PROG_MODE_HI:BIT_PROG_MODE_LO]; // RULE16
                end
                if (PWDATA_I[BIT_PROGRAM_ARM]) begin
                    st_nxt.arm = 1'b1;
                    st_nxt.arm_cnt = ARM_WINDOW_CYCLES; // RULE15
                end
                // go counts only if arm was already set; program go in mode 11 starts nothing
                pg_start = PWDATA_I[BIT_PROGRAM_GO] & st_r.arm & ~st_r.busy &
                           (st_r.mode != MODE_RESERVED); // RULE6 RULE14 RULE18
                rd_start = PWDATA_I[BIT_READ_GO] & ~st_r.busy & ~pg_start; // RULE13 RULE18
            end
        end

        if (pg_start) begin
            st_nxt.busy = 1'b1; // RULE7
            st_nxt.op = st_r.mode; // RULE9 RULE10
            st_nxt.prog_cnt = (st_r.mode == MODE_ATOMIC) ?
                ATOMIC_TICKS : SPLIT_TICKS; // RULE14
            st_nxt.stall_cnt = PROG_STALL_CYCLES; // RULE4
        end

        if (rd_start) begin
            st_nxt.value = mem_rdata; // RULE13
            st_nxt.stall_cnt = READ_STALL_CYCLES; // RULE3
            st_nxt.sts[BIT_STS_READ_DONE] = 1'b1;
        end

        // only oscillator ticks advance the programming time
        if (st_r.busy && osc_edge) begin // RULE12
            if (st_r.prog_cnt <= 12'h1) begin
                st_nxt.busy = 1'b0; // RULE7
                st_nxt.prog_cnt = 12'h0;
                mem_erase = (st_r.op != MODE_WRITE); // RULE6 RULE9
                mem_write = (st_r.op != MODE_ERASE); // RULE6 RULE10
                st_nxt.sts[BIT_STS_PROG_DONE] = 1'b1;
            end else begin
                st_nxt.prog_cnt = st_r.prog_cnt - 12'h1;
            end
        end

        st_nxt.stall = (st_nxt.stall_cnt != 3'h0);
        // ready level follows idle state; sticky events add through the mask
        st_nxt.irq = (st_r.gie & st_r.rie & ~st_r.busy) |
                     (|(st_r.sts & st_r.mask)); // RULE17
    end

    // an async reset cannot finish a running operation; it is abandoned
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            st_r <= '0;
            st_r.addr <= RST_BYTE;
            st_r.value <= RST_BYTE;
            st_r.mode <= RST_MODE; // RULE16
        end else begin
            st_r <= st_nxt;
        end
    end

    assign PRDATA_O = st_r.prdata;
    assign PREADY_O = st_r.pready;
    assign PSLVERR_O = st_r.pslverr;
    assign CPU_STALL_O = st_r.stall;
    assign IRQ_O = st_r.irq;

    // arm write seen on the bus; a fresh arm write restarts the window
    assign arm_wr = commit & PWRITE_I & reg_hit(PADDR_I, OFF_CTRL) &
                    PWDATA_I[BIT_PROGRAM_ARM];

    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!ARST_N_I);

    arm_held_a: assert property ( // RULE15
        arm_wr
        |=> st_r.arm [*4])
        else $error("arm bit dropped inside its window");

    arm_expires_a: assert property ( // RULE15
        arm_wr ##1 !arm_wr [*4]
        |=> !st_r.arm)
        else $error("arm bit not cleared four cycles after set");

    unarmed_go_a: assert property ( // RULE15
        commit && PWRITE_I && reg_hit(PADDR_I, OFF_CTRL) &&
        PWDATA_I[BIT_PROGRAM_GO] && !st_r.arm && !st_r.busy |=> !st_r.busy)
        else $error("program started without arm");

    read_stall_a: assert property ( // RULE3
        rd_start |=> CPU_STALL_O [*4] ##1 !CPU_STALL_O)
        else $error("read stall is not four cycles");

    prog_stall_a: assert property ( // RULE4
        pg_start |=> CPU_STALL_O [*2] ##1 !CPU_STALL_O)
        else $error("program stall is not two cycles");

    prog_time_a: assert property ( // RULE14
        pg_start && st_r.mode == MODE_ATOMIC |=>
        st_r.busy && st_r.prog_cnt == ATOMIC_TICKS)
        else $error("atomic time not loaded");

    osc_timed_a: assert property ( // RULE12
        st_r.busy && !osc_edge |=> $stable(st_r.prog_cnt) && st_r.busy)
        else $error("programming advanced without oscillator tick");

    mode_locked_a: assert property ( // RULE16
        st_r.busy |=> st_r.mode == $past(st_r.mode))
        else $error("mode changed while busy");

    busy_ignore_a: assert property ( // RULE18
        st_r.busy && !pg_start |=> $stable(st_r.addr) && $stable(st_r.value))
        else $error("address or value changed while busy");

    read_value_a: assert property ( // RULE13
        rd_start |=> st_r.value == $past(mem_rdata))
        else $error("read did not load addressed byte");

    ready_irq_a: assert property ( // RULE17
        st_r.gie && st_r.rie && !st_r.busy |=> IRQ_O)
        else $error("ready interrupt missing while idle");

    done_strobe_a: assert property ( // RULE7
        $fell(st_r.busy) |-> $past(mem_erase || mem_write))
        else $error("busy cleared without completing the operation");

    pready_pulse_a: assert property ( // RULE2
        PREADY_O
        |=> !PREADY_O)
        else $error("ready stood for more than one cycle");

    slverr_with_ready_a: assert property ( // RULE2
        PSLVERR_O
        |-> PREADY_O)
        else $error("error response without ready");

    stall_holds_bus_a: assert property ( // RULE3 RULE4
        CPU_STALL_O
        |=> !PREADY_O)
        else $error("bus answered during a stall");

    busy_no_start_a: assert property ( // RULE8 RULE18
        st_r.busy
        |-> !rd_start && !pg_start)
        else $error("operation started while busy");

    reserved_mode_a: assert property ( // RULE14
        st_r.mode == MODE_RESERVED
        |-> !pg_start)
        else $error("reserved mode started programming");

    split_time_a: assert property ( // RULE14
        pg_start && st_r.mode != MODE_ATOMIC
        |=> st_r.busy && st_r.prog_cnt == SPLIT_TICKS)
        else $error("split time not loaded");

    erase_only_a: assert property ( // RULE9
        st_r.op == MODE_ERASE
        |-> !mem_write)
        else $error("erase-only operation wrote the cell");

    write_only_a: assert property ( // RULE10
        st_r.op == MODE_WRITE
        |-> !mem_erase)
        else $error("write-only operation erased the cell");

    atomic_both_a: assert property ( // RULE6
        st_r.op == MODE_ATOMIC && (mem_erase || mem_write)
        |-> mem_erase && mem_write)
        else $error("atomic operation did not erase and write");

    cells_idle_a: assert property ( // RULE8
        !st_r.busy
        |-> !mem_erase && !mem_write)
        else $error("cell strobe while idle");

    irq_off_a: assert property ( // RULE17
        !(st_r.gie && st_r.rie && !st_r.busy) && !(|(st_r.sts & st_r.mask))
        |=> !IRQ_O)
        else $error("interrupt raised with no cause");

    done_status_a: assert property ( // RULE7
        st_r.busy ##1 !st_r.busy
        |-> st_r.sts[BIT_STS_PROG_DONE])
        else $error("program done not flagged");

    atomic_done_c: cover property (
        pg_start && st_r.mode == MODE_ATOMIC ##[1:1000] $fell(st_r.busy));
    erase_start_c: cover property (pg_start && st_r.mode == MODE_ERASE);
    write_start_c: cover property (pg_start && st_r.mode == MODE_WRITE);
    read_c: cover property (rd_start ##[5:8] commit);
    busy_reject_c: cover property (st_r.busy && commit && PWRITE_I);

endmodule : nv_access_ctrl
`default_nettype wire

/* File: tb.sv */
// self-checking bench for nv_access_ctrl over apb
// assumes the block's own register map; oscillator toggles every 4 clocks
`timescale 1ns/100ps
`default_nettype none
module tb;
    import nv_access_pkg::*;
    // short tick counts keep the run brief
    localparam int AT = 8;
    localparam int ST = 4;
    typedef struct {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] q;
        logic e;
    } row_t;
    row_t rows[8] = '{
        '{OFF_ADDR_LO, 32'hffff_ff5a, 32'h5a, 1'b0},
        '{OFF_ADDR_HI, 32'hffff_ffff, 32'h0, 1'b0},
        '{OFF_VALUE, 32'h1234_56c3, 32'hc3, 1'b0},
        '{OFF_IRQ_MASK, 32'hffff_ffff, 32'h3, 1'b0},
        '{OFF_GIE, 32'hffff_fffe, 32'h0, 1'b0},
        '{OFF_CTRL, 32'hffff_ffc8, 32'h8, 1'b0},
        '{OFF_CTRL, 32'h30, 32'h30, 1'b0},
        '{8'h1c, 32'hff, 32'h0, 1'b1}};
    logic [7:0] offs[7] = '{OFF_ADDR_LO, OFF_ADDR_HI, OFF_VALUE, OFF_CTRL,
        OFF_IRQ_STS, OFF_IRQ_MASK, OFF_GIE};
    logic clk = 0, arst_n = 0, psel = 0, pen = 0, pwr = 0, osc = 0;
    logic osc_run = 1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd_v;
    logic pready, pslverr, stall, irq, err_v;
    int errors = 0, checked = 0, ticks = 0, run = 0, slen = 0, t0 = 0;

    nv_access_ctrl #(.ATOMIC_TICKS(12'(AT)), .SPLIT_TICKS(12'(ST))) uut (
        .CLK_SYS_I(clk), .ARST_N_I(arst_n), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .OSC_TOGGLE_I(osc), .CPU_STALL_O(stall), .IRQ_O(irq));

    initial begin
        forever #20 clk = ~clk;
    end
    // length of the last stall burst
    always @(posedge clk) begin
        if (stall === 1'b1) begin
            run <= run + 1;
        end else begin
            if (run != 0) slen <= run;
            run <= 0;
        end
    end
    initial begin
        forever begin
            repeat (4) @(posedge clk);
            if (osc_run) begin
                osc <= ~osc;
                ticks++;
            end
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    // keep holds psel so the next setup follows at once
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input bit keep);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) chk(32'h0, 32'h1);
        rd_v = prdata;
        err_v = pslverr;
        pen <= 1'b0;
        if (!keep) begin
            psel <= 1'b0;
            @(posedge clk);
        end
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0, 1'b0);
    endtask : rd
    // arm then go back to back, inside the arm window
    task automatic prog(input logic [1:0] m, input logic [7:0] a,
                        input logic [7:0] v, input logic [31:0] ie);
        logic [31:0] c;
        c = {26'h0, m, 4'h0} | ie;
        wr(OFF_ADDR_LO, {24'h0, a});
        wr(OFF_VALUE, {24'h0, v});
        wr(OFF_CTRL, c);
        apb(1'b1, OFF_CTRL, c | 32'h4, 1'b1);
        apb(1'b1, OFF_CTRL, c | 32'h2, 1'b0);
        t0 = ticks;
    endtask : prog
    task automatic wait_done(input int n);
        int i;
        int d;
        i = 0;
        do begin
            rd(OFF_CTRL);
            i++;
        end while (rd_v[1] !== 1'b0 && i < 100);
        d = ticks - t0;
        chk({31'h0, d >= n - 1 && d <= n + 2}, 32'h1);
    endtask : wait_done
    task automatic rdop(input logic [7:0] a, input logic [7:0] exp);
        wr(OFF_ADDR_LO, {24'h0, a});
        wr(OFF_CTRL, 32'h1);
        rd(OFF_VALUE);
        chk(rd_v, {24'h0, exp});
        chk(slen, 32'h4);
    endtask : rdop
    task automatic print_verdict();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (20) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        arst_n <= 1'b1;
        @(posedge clk);
        foreach (offs[i]) begin
            rd(offs[i]);
            chk(rd_v, 32'h0);
        end
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            chk(rd_v, rows[i].q);
            chk({31'h0, err_v}, {31'h0, rows[i].e});
        end
        wr(OFF_CTRL, 32'h0);
        wr(OFF_IRQ_MASK, 32'h0);
        prog(MODE_ATOMIC, 8'h5a, 8'ha5, 32'h0);
        rd(OFF_CTRL);
        chk({31'h0, rd_v[1]}, 32'h1);
        chk(slen, 32'h2);
        // requests while busy must leave everything as it was
        wr(OFF_ADDR_LO, 32'h11);
        wr(OFF_VALUE, 32'h77);
        wr(OFF_CTRL, 32'h21);
        rd(OFF_ADDR_LO);
        chk(rd_v, 32'h5a);
        rd(OFF_CTRL);
        chk(rd_v, 32'h2);
        rd(OFF_VALUE);
        chk(rd_v, 32'ha5);
        wait_done(AT);
        rdop(8'h5a, 8'ha5);
        prog(MODE_ERASE, 8'h5a, 8'h00, 32'h0);
        wait_done(ST);
        rdop(8'h5a, ERASED_BYTE);
        prog(MODE_WRITE, 8'h5a, 8'h3c, 32'h0);
        wait_done(ST);
        rdop(8'h5a, 8'h3c);
        prog(MODE_ATOMIC, 8'hff, 8'h81, 32'h0);
        wait_done(AT);
        rdop(8'hff, 8'h81);
        rdop(8'h5a, 8'h3c);
        prog(MODE_RESERVED, 8'h5a, 8'h00, 32'h0);
        rd(OFF_CTRL);
        chk(rd_v, 32'h30);
        wr(OFF_CTRL, 32'h4);
        repeat (3) @(posedge clk);
        rd(OFF_CTRL);
        chk(rd_v, 32'h0);
        wr(OFF_CTRL, 32'h2);
        rd(OFF_CTRL);
        chk(rd_v, 32'h0);
        // stopped oscillator must hold the operation
        osc_run = 1'b0;
        prog(MODE_ERASE, 8'h10, 8'h00, 32'h0);
        repeat (60) @(posedge clk);
        rd(OFF_CTRL);
        chk({31'h0, rd_v[1]}, 32'h1);
        osc_run = 1'b1;
        wait_done(ST);
        rd(OFF_IRQ_STS);
        wr(OFF_GIE, 32'h1);
        wr(OFF_CTRL, 32'h8);
        // look at the level mid-cycle, then drive again after a rising edge
        @(negedge clk);
        chk({31'h0, irq}, 32'h1);
        @(posedge clk);
        prog(MODE_ATOMIC, 8'h20, 8'h55, 32'h8);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        @(posedge clk);
        wait_done(AT);
        @(negedge clk);
        chk({31'h0, irq}, 32'h1);
        @(posedge clk);
        wr(OFF_CTRL, 32'h0);
        wr(OFF_IRQ_MASK, 32'h1);
        @(negedge clk);
        chk({31'h0, irq}, 32'h1);
        @(posedge clk);
        rd(OFF_IRQ_STS);
        chk(rd_v, 32'h1);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        @(posedge clk);
        wr(OFF_IRQ_MASK, 32'h0);
        rdop(8'h20, 8'h55);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        @(posedge clk);
        wr(OFF_IRQ_MASK, 32'h2);
        @(negedge clk);
        chk({31'h0, irq}, 32'h1);
        @(posedge clk);
        rd(OFF_IRQ_STS);
        chk(rd_v, 32'h2);
        // reset in mid-operation; erase only, so no unerased byte is written
        prog(MODE_ERASE, 8'h30, 8'h0f, 32'h0);
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd(OFF_CTRL);
        chk(rd_v, 32'h0);
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        print_verdict();
    end
endmodule : tb
`default_nettype wire
